// ### hw/shc_consts.svh
`ifndef SHC_CONSTS_SVH
`define SHC_CONSTS_SVH

`define SHC_CLK_HZ          40000000
`define SHC_IRQ_PULSE_MS    150
`define SHC_IRQ_PULSE_CYC   (`SHC_CLK_HZ / 1000 * `SHC_IRQ_PULSE_MS)
`define SHC_SEQ_CYC_DEF     400000
`define SHC_TASK_MAX        7'h7F
`define SHC_CAUSE_MAX       5'h10
`define SHC_WORD_W          16
`define SHC_LEN_W           8
`define SHC_BUF_DEPTH       256

`endif

// ### hw/shc_pkg.sv
package shc_pkg;
    typedef enum logic [1:0] {
        SHC_IDLE = 2'b00,
        SHC_SEND = 2'b01,
        SHC_HOLD = 2'b10,
        SHC_RECV = 2'b11
    } shc_state_t;

    typedef struct packed {
        logic       diff_variant;
        logic       auto_mode;
        logic       tx_permit;
        logic       local_ready;
        logic       far_check;
        logic       task_mode;
        logic       hirq_proto;
        logic [6:0] task_num;
        logic [4:0] task_cause;
    } shc_cfg_t;

    typedef struct packed {
        logic       tx_busy;
        logic       tx_error;
        logic       rx_done;
        logic       hw_error;
    } shc_status_t;
endpackage

// ### hw/shc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module shc_sync
    import shc_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } shc_sync_st_t;

    shc_sync_st_t st_q;
    shc_sync_st_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = i_async;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_sync = st_q.s2;
endmodule // shc_sync
`default_nettype wire

// ### hw/shc_host_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "shc_consts.svh"
module shc_host_irq
    import shc_pkg::*;
#(
    parameter int SEQ_CYC   = `SHC_SEQ_CYC_DEF,
    parameter int PULSE_CYC = `SHC_IRQ_PULSE_CYC
) (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    // Control
    input  wire logic i_enable,
    input  wire logic i_coil,
    // Host side
    output logic      o_irq
);
    typedef struct packed {
        logic [31:0] seq_cnt;
        logic [31:0] pulse_cnt;
        logic        coil_prev;
        logic        irq;
    } shc_hirq_st_t;

    shc_hirq_st_t st_q;
    shc_hirq_st_t st_d;
    logic         tick;

    always_comb begin
        st_d = st_q;
        tick = (st_q.seq_cnt == 32'(SEQ_CYC - 1));
        // Free-running sampler, not tied to the sequence cycle
        st_d.seq_cnt = tick ? 32'h0000_0000 : st_q.seq_cnt + 32'h0000_0001;
        if (tick) begin
            st_d.coil_prev = i_coil;
            // Retrigger restarts the count, so close edges stretch
            if (i_coil && !st_q.coil_prev && i_enable) begin
                st_d.pulse_cnt = 32'(PULSE_CYC);
            end
        end
        if (st_d.pulse_cnt == st_q.pulse_cnt && st_q.pulse_cnt != 32'h0) begin
            st_d.pulse_cnt = st_q.pulse_cnt - 32'h0000_0001;
        end
        st_d.irq = i_enable && (st_d.pulse_cnt != 32'h0);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_irq = st_q.irq;
endmodule // shc_host_irq
`default_nettype wire

// ### hw/shc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "shc_consts.svh"
// What this block does
// - Permit asserted: hold transmit-allow line at ready level.
// - Permit deasserted: hold transmit-allow line at not-ready level.
// - Send request without permit stays unsent; busy flag stays set.
// - Single-ended variant sends only with permit asserted.
// - Handshake settings ignored on differential variant.
// - Local-ready setting ready drives ready; default is ready.
// - Local-ready setting not ready drives not ready.
// - Far-ready checking: send only when far ready, else raise error.
// - Checking off by default: far-ready input not looked at.
// - Manual mode default: lines follow individual settings.
// - Automatic mode: transmit-allow only while actually sending.
// - Automatic mode: local-ready ready, not ready on hardware error.
// - Automatic mode checks ready, line-signal and clear inputs.
// - Task mode: reception done starts task number and cause.
// - Host interrupts only on differential variant in host protocol mode.
// - Coil rising edge gives a 150 ms host interrupt pulse.
// - Coil sampled at sequence interval, unsynchronised to it.
// - Send buffer on request; signal reception complete at end.
module shc_ctrl
    import shc_pkg::*;
#(
    parameter int SEQ_CYC = `SHC_SEQ_CYC_DEF
) (
    // Clock and reset
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_rst,
    // Configuration
    input  wire shc_cfg_t                i_cfg,
    // Register port
    input  wire logic [`SHC_LEN_W-1:0]   i_addr,
    input  wire logic [`SHC_WORD_W-1:0]  i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output logic      [`SHC_WORD_W-1:0]  o_rdata,
    // Host sequencing
    input  wire logic                    i_send_req,
    input  wire logic [`SHC_LEN_W-1:0]   i_send_len,
    input  wire logic                    i_rx_buf_empty,
    input  wire logic                    i_hw_error,
    input  wire logic                    i_coil,
    output shc_status_t                  o_status,
    output logic                         o_task_start,
    output logic      [6:0]              o_task_num,
    output logic      [4:0]              o_task_cause,
    output logic                         o_host_irq,
    // Serial line
    output logic                         o_tx_serial_valid,
    output logic      [`SHC_WORD_W-1:0]  o_tx_serial_data,
    input  wire logic                    i_rx_serial_valid,
    input  wire logic [`SHC_WORD_W-1:0]  i_rx_serial_data,
    input  wire logic                    i_rx_serial_last,
    // Modem lines
    output logic                         o_tx_allow_line,
    output logic                         o_local_ready_out,
    input  wire logic                    i_far_ready_in,
    input  wire logic                    i_line_signal_in,
    input  wire logic                    i_tx_clear_in
);
    typedef struct packed {
        shc_state_t              state;
        logic [`SHC_LEN_W-1:0]   idx;
        logic [`SHC_LEN_W-1:0]   len;
        logic [`SHC_LEN_W-1:0]   rx_cnt;
        logic [`SHC_WORD_W-1:0]  rdata;
        logic [`SHC_WORD_W-1:0]  tx_data;
        logic                    tx_valid;
        logic                    tx_allow;
        logic                    lready;
        logic                    task_start;
        logic [6:0]              task_num;
        logic [4:0]              task_cause;
        shc_status_t             status;
    } shc_ctrl_st_t;

    shc_ctrl_st_t st_q;
    shc_ctrl_st_t st_d;

    // Send buffer is written by the register port, receive buffer by the line
    logic [`SHC_WORD_W-1:0] send_buf [`SHC_BUF_DEPTH];
    logic [`SHC_WORD_W-1:0] recv_buf [`SHC_BUF_DEPTH];

    logic [2:0] pins_s;
    logic       far_ready_s;
    logic       line_sig_s;
    logic       tx_clear_s;
    logic       irq_en;
    logic       hs_active;
    logic       permit;
    logic       far_ok;
    logic       may_send;

    shc_sync #(
        .W (3)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_async   ({i_far_ready_in, i_line_signal_in, i_tx_clear_in}),
        .o_sync    (pins_s)
    );

    assign far_ready_s = pins_s[2];
    assign line_sig_s  = pins_s[1];
    assign tx_clear_s  = pins_s[0];

    assign irq_en = i_cfg.diff_variant && i_cfg.hirq_proto;

    shc_host_irq #(
        .SEQ_CYC (SEQ_CYC)
    ) u_host_irq (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_enable  (irq_en),
        .i_coil    (i_coil),
        .o_irq     (o_host_irq)
    );

    always_comb begin
        hs_active = !i_cfg.diff_variant;
        // Automatic mode needs the far side ready, carrier and clear
        if (i_cfg.auto_mode) begin
            permit = 1'b1;
            far_ok = far_ready_s && line_sig_s && tx_clear_s;
        end else begin
            permit = i_cfg.tx_permit;
            // Checking off means the pin is never consulted
            far_ok = !i_cfg.far_check || far_ready_s;
        end
        may_send = !hs_active || (permit && far_ok);
    end

    always_comb begin
        st_d            = st_q;
        st_d.tx_valid   = 1'b0;
        st_d.task_start = 1'b0;
        st_d.rdata      = '0;
        if (i_rd) begin
            st_d.rdata = (i_addr == '0) ? {12'h000, st_q.status}
                                        : recv_buf[i_addr];
        end
        unique case (st_q.state)
            SHC_IDLE: begin
                if (i_send_req) begin
                    // Launch latches length, zeroes idx, clears tx_error and sets busy; permit and far-ready checks happen in SHC_HOLD
                    st_d.len            = i_send_len;
                    st_d.idx            = '0;
                    st_d.status.tx_busy = 1'b1;
                    st_d.state          = SHC_HOLD;
                end
            end
            SHC_HOLD: begin
                if (may_send) begin
                    st_d.state = SHC_SEND;
                end else if (hs_active && permit && !far_ok) begin
                    st_d.status.tx_error = 1'b1;
                    st_d.status.tx_busy  = 1'b0;
                    st_d.state           = SHC_IDLE;
                end
                // No permit: data held, busy stays set
            end
            SHC_SEND: begin
                st_d.tx_valid = 1'b1;
                st_d.tx_data  = send_buf[st_q.idx];
                st_d.idx      = st_q.idx + 8'h01;
                if (st_q.idx + 8'h01 == st_q.len || st_q.len == '0) begin
                    st_d.status.tx_busy = 1'b0;
                    st_d.state          = SHC_IDLE;
                end
            end
            SHC_RECV: begin
                st_d.state = SHC_IDLE;
            end
        endcase
        st_d.task_num   = i_cfg.task_num;
        st_d.task_cause = (i_cfg.task_cause > `SHC_CAUSE_MAX)
                          ? `SHC_CAUSE_MAX : i_cfg.task_cause;
        if (i_send_req && st_q.state == SHC_IDLE) begin
            st_d.status.tx_error = 1'b0;
        end
        if (i_rx_serial_valid) begin
            st_d.rx_cnt = st_q.rx_cnt + 8'h01;
            if (i_rx_serial_last) begin
                st_d.status.rx_done = 1'b1;
                st_d.task_start     = i_cfg.task_mode;
            end
        end
        // Host empties buffer; a new completion in the same cycle wins
        if (i_rx_buf_empty && !(i_rx_serial_valid && i_rx_serial_last)) begin
            st_d.status.rx_done = 1'b0;
            st_d.rx_cnt         = '0;
        end
        if (i_hw_error) begin
            st_d.status.hw_error = 1'b1;
        end
        // Handshake outputs
        if (!hs_active) begin
            st_d.tx_allow = 1'b1;
            st_d.lready   = 1'b1;
        end else if (i_cfg.auto_mode) begin
            // Rides with each word, so it never leads or trails one
            st_d.tx_allow = st_d.tx_valid;
            st_d.lready   = !st_d.status.hw_error;
        end else begin
            st_d.tx_allow = i_cfg.tx_permit;
            st_d.lready   = i_cfg.local_ready;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_wr && i_addr != '0) begin
            send_buf[i_addr] <= i_wdata;
        end
        if (i_rx_serial_valid) begin
            recv_buf[st_q.rx_cnt] <= i_rx_serial_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_q        <= '0;
            st_q.lready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata           = st_q.rdata;
    assign o_status          = st_q.status;
    assign o_task_start      = st_q.task_start;
    assign o_task_num        = st_q.task_num;
    assign o_task_cause      = st_q.task_cause;
    assign o_tx_serial_valid = st_q.tx_valid;
    assign o_tx_serial_data  = st_q.tx_data;
    assign o_tx_allow_line   = st_q.tx_allow;
    assign o_local_ready_out = st_q.lready;
endmodule // shc_ctrl
`default_nettype wire

// ### verification/shc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module shc_chk
    import shc_pkg::*;
(
    // Watched ports
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire shc_cfg_t    i_cfg,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        i_rx_serial_valid,
    input wire logic        i_rx_serial_last,
    input wire shc_status_t o_status,
    input wire logic        o_task_start,
    input wire logic        o_host_irq,
    input wire logic        o_tx_serial_valid,
    input wire logic        o_tx_allow_line,
    input wire logic        o_local_ready_out
);
    logic man_se;
    logic auto_se;
    assign man_se  = !i_cfg.diff_variant && !i_cfg.auto_mode;
    assign auto_se = !i_cfg.diff_variant && i_cfg.auto_mode;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_permit_high : assert property
        ((man_se && i_cfg.tx_permit)[*3] |-> o_tx_allow_line)
        else $error("Allow line low with permit set");
    a_permit_low : assert property
        ((man_se && !i_cfg.tx_permit)[*3] |-> !o_tx_allow_line)
        else $error("Allow line high with permit clear");
    a_ready_level : assert property
        ((man_se && $stable(i_cfg.local_ready))[*3]
         |-> o_local_ready_out == i_cfg.local_ready)
        else $error("Local ready differs from setting");
    a_diff_lines : assert property
        (i_cfg.diff_variant[*3] |-> o_tx_allow_line && o_local_ready_out)
        else $error("Handshake lines moved on differential variant");
    a_hold_unsent : assert property
        ((man_se && !i_cfg.tx_permit)[*3] |-> !o_tx_serial_valid)
        else $error("Word sent without permit");
    a_auto_send : assert property
        (auto_se && o_tx_serial_valid |-> ##[0:1] o_tx_allow_line)
        else $error("Automatic allow line absent while sending");
    a_auto_idle : assert property
        ((auto_se && !o_status.tx_busy)[*3] |-> !o_tx_allow_line)
        else $error("Automatic allow line high while idle");
    a_task_pulse : assert property
        (o_task_start |-> $past(i_rx_serial_valid && i_rx_serial_last
         && i_cfg.task_mode) ##1 !o_task_start)
        else $error("Task start without completed reception");
    a_rx_done : assert property
        (i_rx_serial_valid && i_rx_serial_last |=> o_status.rx_done)
        else $error("Reception complete not flagged");
    a_irq_gate : assert property
        ($rose(o_host_irq)
         |-> $past(i_cfg.diff_variant && i_cfg.hirq_proto))
        else $error("Host interrupt outside host protocol mode");
    a_rdata_idle : assert property
        (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("Read data outside read answer cycle");

    c_task : cover property (o_task_start);
    c_irq  : cover property ($rose(o_host_irq));
    c_err  : cover property ($rose(o_status.tx_error));
endmodule // shc_chk

bind shc_ctrl shc_chk chk_u (.i_ref_clk, .i_rst, .i_cfg, .i_rd, .o_rdata,
    .i_rx_serial_valid, .i_rx_serial_last, .o_status, .o_task_start,
    .o_host_irq, .o_tx_serial_valid, .o_tx_allow_line, .o_local_ready_out);
`default_nettype wire

// ### verification/shc_remote.sv
`timescale 1ns/1ps
`default_nettype none
module shc_remote (
    // Control from bench
    input  wire logic        i_ref_clk,
    input  wire logic        i_far_rdy,
    input  wire logic        i_frame_go,
    input  wire logic        i_clr,
    // Line from device
    input  wire logic        i_tx_valid,
    input  wire logic [15:0] i_tx_data,
    // Line to device
    output logic             o_far_ready,
    output logic             o_rx_valid,
    output logic      [15:0] o_rx_data,
    output logic             o_rx_last,
    // Observation
    output int               o_tx_cnt,
    output logic      [15:0] o_tx_word1
);
    logic [2:0] step_q;
    initial begin
        {o_far_ready, o_rx_valid, o_rx_last, step_q} = '0;
        o_rx_data  = 16'h0000;
        o_tx_cnt   = 0;
        o_tx_word1 = 16'h0000;
    end
    // Slow sender: idle cycle between words, data toggles when idle
    always @(posedge i_ref_clk) begin
        o_far_ready <= i_far_rdy;
        if (i_clr) o_tx_cnt <= 0;
        else if (i_tx_valid) o_tx_cnt <= o_tx_cnt + 1;
        if (i_tx_valid && o_tx_cnt == 1) o_tx_word1 <= i_tx_data;
        if (i_frame_go) step_q <= 3'h1;
        else if (step_q == 3'h0 || step_q == 3'h5) step_q <= 3'h0;
        else step_q <= step_q + 3'h1;
        o_rx_valid <= step_q[0];
        o_rx_last  <= step_q == 3'h5;
        o_rx_data  <= step_q[0] ? {13'h0A5C, step_q} : ~o_rx_data;
    end
endmodule // shc_remote
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import shc_pkg::*;
    localparam int SEQ = 10;
    typedef struct packed {logic [3:0] set; logic [1:0] exp;} shc_row_t;
    logic        i_ref_clk = 1'b0, i_rst = 1'b1;
    shc_cfg_t    i_cfg = 19'h18000;
    logic [7:0]  i_addr = 8'h00, i_send_len = 8'h00;
    logic [15:0] i_wdata = 16'h0000, o_rdata, o_tx_serial_data, d;
    logic [15:0] i_rx_serial_data, tx_word1;
    logic        i_wr = 0, i_rd = 0, i_send_req = 0, i_rx_buf_empty = 0;
    logic        i_hw_error = 0, i_coil = 0, far_rdy = 1, frame_go = 0;
    logic        clr = 0, o_task_start, o_host_irq, o_tx_serial_valid;
    logic        i_rx_serial_valid, i_rx_serial_last, o_tx_allow_line;
    logic        o_local_ready_out, i_far_ready_in;
    logic        i_line_signal_in = 1'b1, i_tx_clear_in = 1'b1;
    logic [6:0]  o_task_num;
    logic [4:0]  o_task_cause;
    shc_status_t o_status;
    int          miscompares = 0, cmp_count = 0, cyc = 0, tx_cnt, k;
    // {diff, auto, permit, ready} -> {allow, ready}
    shc_row_t rows [5] = '{'{4'h3, 2'h3}, '{4'h0, 2'h0}, '{4'h2, 2'h2},
                           '{4'h8, 2'h3}, '{4'h4, 2'h1}};

    shc_ctrl #(.SEQ_CYC(SEQ)) dut_u (.i_ref_clk, .i_rst, .i_cfg, .i_addr,
        .i_wdata, .i_wr, .i_rd, .o_rdata, .i_send_req, .i_send_len,
        .i_rx_buf_empty, .i_hw_error, .i_coil, .o_status, .o_task_start,
        .o_task_num, .o_task_cause, .o_host_irq, .o_tx_serial_valid,
        .o_tx_serial_data, .i_rx_serial_valid, .i_rx_serial_data,
        .i_rx_serial_last, .o_tx_allow_line, .o_local_ready_out,
        .i_far_ready_in, .i_line_signal_in, .i_tx_clear_in);
    shc_remote rem_u (.i_ref_clk, .i_far_rdy(far_rdy), .i_frame_go(frame_go),
        .i_clr(clr), .i_tx_valid(o_tx_serial_valid),
        .i_tx_data(o_tx_serial_data), .o_far_ready(i_far_ready_in),
        .o_rx_valid(i_rx_serial_valid), .o_rx_data(i_rx_serial_data),
        .o_rx_last(i_rx_serial_last), .o_tx_cnt(tx_cnt),
        .o_tx_word1(tx_word1));

    initial begin
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    task automatic end_of_test;
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            $display("[FAIL] %0t run did not finish", $time);
            end_of_test();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= w;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Host side: buffer already filled, then start
    task automatic send(input logic [7:0] n);
        @(posedge i_ref_clk);
        i_send_len <= n;
        i_send_req <= 1'b1;
        clr <= 1'b1;
        @(posedge i_ref_clk);
        i_send_req <= 1'b0;
        clr <= 1'b0;
        #1 chk({15'h0, o_status.tx_busy}, 16'h0001);
        for (k = 0; k < 60 && o_status.tx_busy !== 1'b0; k++) tick(1);
        // Last word is still on the line when busy drops
        tick(1);
    endtask

    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        #1 d = 16'({o_status, o_tx_allow_line, o_local_ready_out});
        chk(d, 16'h0001);
        foreach (rows[r]) begin
            @(posedge i_ref_clk);
            {i_cfg.diff_variant, i_cfg.auto_mode, i_cfg.tx_permit,
             i_cfg.local_ready} <= rows[r].set;
            tick(4);
            d = 16'({o_tx_allow_line, o_local_ready_out});
            chk(d, 16'(rows[r].exp));
        end
        i_cfg <= 19'h18000;
        wr(8'h01, 16'h1111);
        wr(8'h02, 16'h2222);
        send(8'h03);
        chk(tx_word1, 16'h1111);
        chk(16'({o_status.tx_busy, o_status.tx_error}), 16'h0000);
        i_cfg.tx_permit <= 1'b0;
        tick(4);
        fork send(8'h00); join_none
        tick(24);
        chk({o_status.tx_busy, 15'(tx_cnt)}, 16'h8000);
        i_cfg.tx_permit <= 1'b1;
        tick(30);
        chk({o_status.tx_busy, 15'(tx_cnt)}, 16'h0001);
        far_rdy <= 1'b0;
        i_cfg.far_check <= 1'b1;
        tick(4);
        send(8'h00);
        chk({o_status.tx_error, 15'(tx_cnt)}, 16'h8000);
        i_cfg.far_check <= 1'b0;
        send(8'h00);
        chk(16'(tx_cnt), 16'h0001);
        i_cfg.auto_mode <= 1'b1;
        far_rdy <= 1'b1;
        tick(4);
        send(8'h01);
        chk(16'(tx_cnt), 16'h0001);
        i_tx_clear_in <= 1'b0;
        tick(4);
        send(8'h00);
        chk({o_status.tx_error, 15'(tx_cnt)}, 16'h8000);
        i_tx_clear_in <= 1'b1;
        i_hw_error <= 1'b1;
        tick(1);
        i_hw_error <= 1'b0;
        tick(3);
        chk({15'h0, o_local_ready_out}, 16'h0000);
        rd(8'h00);
        chk({15'h0, d[0]}, 16'h0001);
        i_cfg <= 19'h44000;
        far_rdy <= 1'b0;
        tick(3);
        send(8'h00);
        chk({o_status.tx_error, 15'(tx_cnt)}, 16'h0001);
        i_cfg <= {7'h42, 7'h55, 5'h1F};
        tick(2);
        chk(16'({o_task_num, o_task_cause}), 16'h0AB0);
        i_cfg.task_cause <= 5'h10;
        frame_go <= 1'b1;
        tick(1);
        frame_go <= 1'b0;
        for (k = 0; k < 20 && o_task_start !== 1'b1; k++) tick(1);
        chk(16'({o_task_start, o_task_cause}), 16'h0030);
        tick(1);
        chk({15'h0, o_status.rx_done}, 16'h0001);
        wr(8'h00, 16'h0000);
        rd(8'h00);
        chk({15'h0, d[1]}, 16'h0001);
        rd(8'h01);
        chk(d, {13'h0A5C, 3'h3});
        i_rx_buf_empty <= 1'b1;
        tick(1);
        i_rx_buf_empty <= 1'b0;
        tick(1);
        chk({15'h0, o_status.rx_done}, 16'h0000);
        i_coil <= 1'b1;
        tick(4 * SEQ);
        chk({15'h0, o_host_irq}, 16'h0000);
        i_coil <= 1'b0;
        i_cfg.hirq_proto <= 1'b1;
        tick(3 * SEQ);
        i_coil <= 1'b1;
        tick(3 * SEQ);
        chk({15'h0, o_host_irq}, 16'h0001);
        i_rst <= 1'b1;
        tick(2);
        i_rst <= 1'b0;
        d = 16'({o_status, o_tx_allow_line, o_local_ready_out, o_host_irq});
        chk(d, 16'h0002);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
